// [design/dalr_top.sv]
// Dual-channel sample router: conversion, edge selection, fixed latency.
// Assumes sample ports are synchronous to ref_clk_i; fall ports carry the
// value seen at the falling edge half a cycle after the previous rise.
`include "dalr_defines.svh"

// What this block does
// R1: Samples are converted every clock with no start command.
// R2: Normal mode uses rising samples only; interleaved mode uses rising and falling.
// R3: Primary buses show own-input rising samples after 35 cycles, delayed buses after 36.
// R4: Interleaved demux puts rising samples on I buses at 35/36 and falling on Q buses at 35.5/36.5.
// R5: Without demux both delayed buses are held at zero with delayed_oe_n_o high, and only primary buses carry data.
// R6: Interleaved mode defaults to the I input; Q-only and dual-driven options exist.
// R7: The Q input may feed interleaved mode only under extended register control.
// R8: Without extended control one select pin sets one full-scale range for both channels.
// R9: Under extended control each channel has its own 15-bit full-scale register.
// R10: In dual-driven mode the source drives both inputs with one identical signal.
// R11: Each sample is a 10-bit code clipped to all ones above and all zeros below range.
// R12: Capture logic aligns each bus to the fixed latency of the active mode.
module dalr_top import dalr_pkg::*; #(
  parameter int AIN_W = 12,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [AIN_W-1:0] ain_i_rise_i,
  input wire logic [AIN_W-1:0] ain_i_fall_i,
  input wire logic [AIN_W-1:0] ain_q_rise_i,
  input wire logic [AIN_W-1:0] ain_q_fall_i,
  input wire logic extended_register_control_i,
  input wire logic des_pin_i,
  input wire logic demux_pin_i,
  input wire logic full_scale_select_i,
  output logic [9:0] i_primary_bus_o,
  output logic [9:0] q_primary_bus_o,
  output logic [9:0] i_delayed_bus_o,
  output logic [9:0] q_delayed_bus_o,
  output logic delayed_oe_n_o,
  output logic [9:0] snap_data_o,
  output logic snap_valid_o,
  input wire logic snap_ready_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LAT = `DALR_LAT_PRIMARY;

  initial begin
    if (AIN_W < 2 || AIN_W > 16 || FIFO_DEPTH < 2 || `DALR_LAT_DELAYED != LAT + 1) begin
      $error("dalr_top: unsupported parameter values");
    end
  end

  // Register file
  dalr_ctrl_t ctrl, next_ctrl;
  logic [14:0] fsr_i, next_fsr_i, fsr_q, next_fsr_q;
  logic [15:0] overrun, next_overrun;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  logic rd_ok, wr_ok, do_write;
  logic [3:0] rd_idx, wr_idx;

  assign wr_idx = aw_addr[5:2];
  assign rd_idx = s_axi_araddr[5:2];
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = (aw_addr[31:6] == '0) && (aw_addr[1:0] == 2'h0) &&
                 (wr_idx == `DALR_IDX_CTRL || wr_idx == `DALR_IDX_FSR_I || wr_idx == `DALR_IDX_FSR_Q);

  // Effective mode, pins or registers
  logic des_m, demux_m;
  dalr_src_t src_m;
  logic [14:0] gain_pin, gain_i, gain_q;

  always_comb begin
    rd_ok = (s_axi_araddr[31:6] == '0) && (s_axi_araddr[1:0] == 2'h0);
    rd_word = '0;
    unique case (rd_idx)
      `DALR_IDX_CTRL: rd_word = {27'h0, ctrl};
      `DALR_IDX_STAT: rd_word = {overrun, 11'h0, src_m, demux_m, des_m, extended_register_control_i};
      `DALR_IDX_FSR_I: rd_word = {17'h0, fsr_i};
      `DALR_IDX_FSR_Q: rd_word = {17'h0, fsr_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_fsr_i = fsr_i;
    next_fsr_q = fsr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? `DALR_RESP_OKAY : `DALR_RESP_SLVERR;
      if (wr_ok && wr_idx == `DALR_IDX_CTRL && w_strb[0]) begin
        next_ctrl = dalr_ctrl_t'(w_data[4:0]);
        // Reserved source code falls back to the I input
        if (w_data[`DALR_CTRL_SRC_HI:`DALR_CTRL_SRC_LO] == 2'h3) begin
          next_ctrl.src = DALR_SRC_I;
        end
      end
      // R9 independent range words
      if (wr_ok && wr_idx == `DALR_IDX_FSR_I) begin
        if (w_strb[0]) next_fsr_i[7:0] = w_data[7:0];
        if (w_strb[1]) next_fsr_i[14:8] = w_data[14:8];
      end
      if (wr_ok && wr_idx == `DALR_IDX_FSR_Q) begin
        if (w_strb[0]) next_fsr_q[7:0] = w_data[7:0];
        if (w_strb[1]) next_fsr_q[14:8] = w_data[14:8];
      end
    end
  end

  always_comb begin
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_ok ? rd_word : 32'h0;
      next_rresp = rd_ok ? `DALR_RESP_OKAY : `DALR_RESP_SLVERR;
    end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= dalr_ctrl_t'(`DALR_CTRL_RST);
      fsr_i <= `DALR_FSR_RST;
      fsr_q <= `DALR_FSR_RST;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      fsr_i <= next_fsr_i;
      fsr_q <= next_fsr_q;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      // Ready only while the holding slot is free, so one write is in flight
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  always_comb begin
    des_m = extended_register_control_i ? ctrl.des : des_pin_i;
    demux_m = extended_register_control_i ? ctrl.demux : demux_pin_i;
    // R6 default input, R7 Q only under extended control
    src_m = extended_register_control_i ? ctrl.src : DALR_SRC_I;
    // R8 one pin for both channels
    gain_pin = full_scale_select_i ? `DALR_GAIN_PIN_HI : `DALR_GAIN_PIN_LO;
    gain_i = extended_register_control_i ? fsr_i : gain_pin;
    gain_q = extended_register_control_i ? fsr_q : gain_pin;
  end

  // R11 scale, clip, offset binary
  function automatic logic [9:0] dalr_conv(input logic [AIN_W-1:0] a, input logic [14:0] g);
    logic signed [AIN_W+16:0] p;
    logic signed [AIN_W+16:0] s;
    p = (AIN_W + 17)'($signed(a)) * (AIN_W + 17)'($signed({1'b0, g}));
    s = p >>> `DALR_GAIN_SHIFT;
    if (s > (AIN_W + 17)'(511)) begin
      dalr_conv = 10'h3FF;
    end else if (s < -(AIN_W + 17)'(512)) begin
      dalr_conv = 10'h000;
    end else begin
      dalr_conv = {~s[9], s[8:0]};
    end
  endfunction

  // Capture stage: rising samples for I side, falling or Q samples for Q side
  logic [9:0] next_cap_i, next_cap_q;
  logic [9:0] pipe_i [LAT];
  logic [9:0] pipe_q [LAT];

  always_comb begin
    // R2 normal mode, rising samples of each input
    next_cap_i = dalr_conv(ain_i_rise_i, gain_i);
    next_cap_q = dalr_conv(ain_q_rise_i, gain_q);
    if (des_m) begin
      // R4 interleaved, both edges of the chosen input; dual-driven takes I rising and Q falling
      unique case (src_m)
        DALR_SRC_Q: begin
          next_cap_i = dalr_conv(ain_q_rise_i, gain_q);
          next_cap_q = dalr_conv(ain_q_fall_i, gain_q);
        end
        // R10 both inputs carry one signal, so each edge may use either
        DALR_SRC_IQ: begin
          next_cap_i = dalr_conv(ain_i_rise_i, gain_i);
          next_cap_q = dalr_conv(ain_q_fall_i, gain_q);
        end
        default: begin
          next_cap_i = dalr_conv(ain_i_rise_i, gain_i);
          next_cap_q = dalr_conv(ain_i_fall_i, gain_i);
        end
      endcase
    end
  end

  // R1 free-running pipeline, no start
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pipe_i[0] <= '0;
      pipe_q[0] <= '0;
    end else begin
      pipe_i[0] <= next_cap_i;
      pipe_q[0] <= next_cap_q;
    end
  end

  for (genvar k = 1; k < LAT; k++) begin : g_pipe
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pipe_i[k] <= '0;
        pipe_q[k] <= '0;
      end else begin
        pipe_i[k] <= pipe_i[k-1];
        pipe_q[k] <= pipe_q[k-1];
      end
    end
  end

  // Output stage
  logic [9:0] next_i_dly, next_q_dly;
  logic next_oe_n;

  always_comb begin
    // R5 delayed buses idle and released without demux
    next_oe_n = !demux_m;
    next_i_dly = demux_m ? i_primary_bus_o : 10'h000;
    next_q_dly = demux_m ? q_primary_bus_o : 10'h000;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      i_primary_bus_o <= '0;
      q_primary_bus_o <= '0;
      i_delayed_bus_o <= '0;
      q_delayed_bus_o <= '0;
      delayed_oe_n_o <= 1'b1;
    end else begin
      // R3 primary at 35, delayed one later at 36
      i_primary_bus_o <= pipe_i[LAT-1];
      q_primary_bus_o <= pipe_q[LAT-1];
      i_delayed_bus_o <= next_i_dly;
      q_delayed_bus_o <= next_q_dly;
      delayed_oe_n_o <= next_oe_n;
    end
  end

  // Snapshot of the I primary bus; a full buffer drops and counts samples
  dalr_stream_if #(.W(10)) snap_if ();
  assign snap_if.valid = ctrl.snap;
  assign snap_if.data = i_primary_bus_o;

  always_comb begin
    next_overrun = overrun;
    if (snap_if.valid && !snap_if.ready && overrun != 16'hFFFF) begin
      next_overrun = overrun + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overrun <= '0;
    end else begin
      overrun <= next_overrun;
    end
  end

  dalr_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_snap_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .wr(snap_if),
    .rd_data_o(snap_data_o),
    .rd_valid_o(snap_valid_o),
    .rd_ready_i(snap_ready_i)
  );
endmodule

// [design/dalr_defines.svh]
// Register indices, field positions, reset values and pipeline counts.
// Assumes 32-bit AXI4-Lite data; byte address is four times the index.
`ifndef DALR_DEFINES_SVH
`define DALR_DEFINES_SVH

`define DALR_IDX_CTRL 4'h0
`define DALR_IDX_STAT 4'h1
`define DALR_IDX_FSR_I 4'h3
`define DALR_IDX_FSR_Q 4'hB

`define DALR_CTRL_DES 0
`define DALR_CTRL_DEMUX 1
`define DALR_CTRL_SRC_LO 2
`define DALR_CTRL_SRC_HI 3
`define DALR_CTRL_SNAP 4

`define DALR_CTRL_RST 5'h00
`define DALR_FSR_RST 15'h4000
`define DALR_GAIN_PIN_LO 15'h5000
`define DALR_GAIN_PIN_HI 15'h4000
`define DALR_GAIN_SHIFT 14

`define DALR_LAT_PRIMARY 34
`define DALR_LAT_DELAYED 35

`define DALR_RESP_OKAY 2'h0
`define DALR_RESP_SLVERR 2'h2

`endif

// [design/dalr_pkg.sv]
// Types for the router's control register and source select.
// Assumes dalr_defines.svh supplies the numeric constants.
package dalr_pkg;
  typedef enum logic [1:0] {
    DALR_SRC_I = 2'h0,
    DALR_SRC_Q = 2'h1,
    DALR_SRC_IQ = 2'h2
  } dalr_src_t;

  typedef struct packed {
    logic snap;
    dalr_src_t src;
    logic demux;
    logic des;
  } dalr_ctrl_t;
endpackage

// [design/dalr_stream_if.sv]
// Valid/ready stream carrier between the router and its buffer.
// Assumes both ends share one clock.
interface dalr_stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [design/dalr_fifo.sv]
// Synchronous FIFO with a registered show-ahead output stage.
// Assumes one clock; the drain side may hold ready low for any time.
module dalr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  dalr_stream_if.snk wr,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1 || wr.W != WIDTH) begin
      $error("dalr_fifo: DEPTH must be a power of two >= 2 and widths must match");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [AW:0] count, next_count;
  logic [WIDTH-1:0] next_rd_data;
  logic next_rd_valid, push, pop;

  // Full counts the output stage too, so at most DEPTH words wait in all
  assign wr.ready = ((count + (AW + 1)'(rd_valid_o)) != (AW + 1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  assign pop = (count != '0) && (!rd_valid_o || rd_ready_i);

  always_comb begin
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_rd_data = pop ? mem[rptr] : rd_data_o;
    next_rd_valid = pop ? 1'b1 : (rd_valid_o && !rd_ready_i);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      rd_data_o <= next_rd_data;
      rd_valid_o <= next_rd_valid;
    end
  end

  // Storage carries no reset so it can map to RAM
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end
endmodule

// [sim/dalr_top_checker.sv]
// Concurrent checks on the sample router's ports.
// Assumes it is bound to dalr_top and that one clock drives everything.
module dalr_top_checker #(
  parameter int AIN_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [AIN_W-1:0] ain_i_rise_i,
  input wire logic [AIN_W-1:0] ain_i_fall_i,
  input wire logic [AIN_W-1:0] ain_q_rise_i,
  input wire logic extended_register_control_i,
  input wire logic des_pin_i,
  input wire logic full_scale_select_i,
  input wire logic [9:0] i_primary_bus_o,
  input wire logic [9:0] q_primary_bus_o,
  input wire logic [9:0] i_delayed_bus_o,
  input wire logic [9:0] q_delayed_bus_o,
  input wire logic delayed_oe_n_o,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  localparam int gain_hi = 32'h0000_4000;
  localparam int gain_lo = 32'h0000_5000;
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic [5:0] run;
  logic [5:0] next_run;
  logic settled;

  function automatic logic [9:0] conv(input logic [AIN_W-1:0] a, input logic hi);
    int v;
    v = (int'($signed(a)) * (hi ? gain_hi : gain_lo)) >>> 14;
    if (v > 511) v = 511;
    if (v < -512) v = -512;
    return 10'(v + 512);
  endfunction

  // Pin mode must stand still past the pipeline depth before outputs are judged
  always_comb begin
    next_mode = {extended_register_control_i, des_pin_i, full_scale_select_i};
    next_run = run;
    if (next_mode != mode) next_run = 6'h00;
    else if (run != 6'h3F) next_run = run + 6'h01;
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= 3'h0;
      run <= 6'h00;
    end else begin
      mode <= next_mode;
      run <= next_run;
    end
  end
  assign settled = run > 6'h26 && !mode[2];

  a_i_rise_lat: assert property (settled |->
    i_primary_bus_o == conv($past(ain_i_rise_i, 35), mode[0])) else $error("I primary bus wrong");
  a_q_rise_lat: assert property (settled && !mode[1] |->
    q_primary_bus_o == conv($past(ain_q_rise_i, 35), mode[0])) else $error("Q primary bus wrong");
  a_des_q_fall: assert property (settled && mode[1] |->
    q_primary_bus_o == conv($past(ain_i_fall_i, 35), mode[0])) else $error("Q bus not falling sample");
  a_delayed_idle: assert property (delayed_oe_n_o |->
    i_delayed_bus_o == 10'h000 && q_delayed_bus_o == 10'h000) else $error("Idle delayed bus active");
  a_delayed_lag: assert property (!delayed_oe_n_o && !$past(delayed_oe_n_o) |->
    i_delayed_bus_o == $past(i_primary_bus_o) && q_delayed_bus_o == $past(q_primary_bus_o))
    else $error("Delayed bus lag wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready longer than a cycle");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");

  c_des: cover property (settled && mode[1]);
  c_demux: cover property (!delayed_oe_n_o ##1 !delayed_oe_n_o);
  c_read: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
endmodule

bind dalr_top dalr_top_checker #(.AIN_W(AIN_W)) u_checker (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ain_i_rise_i(ain_i_rise_i), .ain_i_fall_i(ain_i_fall_i),
  .ain_q_rise_i(ain_q_rise_i), .extended_register_control_i(extended_register_control_i),
  .des_pin_i(des_pin_i), .full_scale_select_i(full_scale_select_i), .i_primary_bus_o(i_primary_bus_o),
  .q_primary_bus_o(q_primary_bus_o), .i_delayed_bus_o(i_delayed_bus_o), .q_delayed_bus_o(q_delayed_bus_o),
  .delayed_oe_n_o(delayed_oe_n_o), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// [sim/dalr_capture_model.sv]
// Downstream capture logic that drains the snapshot stream.
// Assumes the shared clock and valid/ready transfers.
module dalr_capture_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [9:0] data_i,
  input wire logic valid_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic [9:0] last_o,
  output logic [7:0] count_o
);
  // Half-rate ready when running, so the source also meets a slow taker
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o <= 1'b0;
      count_o <= 8'h00;
      last_o <= 10'h000;
    end else begin
      ready_o <= !stall_i && !ready_o;
      if (valid_i && ready_o) begin
        count_o <= count_o + 8'h01;
        last_o <= data_i;
      end
    end
  end
endmodule

// [sim/testbench.sv]
// Bench for the sample router: registers, latency, routing, snapshot buffer.
// Assumes the capture model drains the snapshot stream.
`include "dalr_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int gain_hi = 32'h0000_4000;
  localparam int gain_lo = 32'h0000_5000;
  // One edge more: the output register follows the 34-stage pipeline
  localparam int lat_p = `DALR_LAT_PRIMARY + 1;
  logic clk = 1'b0;
  logic rstn, ext, desp, dmxp, fsp, stall, oen, sv, sr;
  logic [11:0] air, aif, aqr, aqf;
  logic [9:0] ip, qp, id, qd, sd, last;
  logic [7:0] cnt;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int err_count = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;

  dalr_top DUT (.ref_clk_i(clk), .rstn_i(rstn), .ain_i_rise_i(air), .ain_i_fall_i(aif),
    .ain_q_rise_i(aqr), .ain_q_fall_i(aqf), .extended_register_control_i(ext), .des_pin_i(desp),
    .demux_pin_i(dmxp), .full_scale_select_i(fsp), .i_primary_bus_o(ip), .q_primary_bus_o(qp),
    .i_delayed_bus_o(id), .q_delayed_bus_o(qd), .delayed_oe_n_o(oen), .snap_data_o(sd),
    .snap_valid_o(sv), .snap_ready_i(sr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dalr_capture_model u_cap (.ref_clk_i(clk), .rstn_i(rstn), .data_i(sd), .valid_i(sv),
    .stall_i(stall), .ready_o(sr), .last_o(last), .count_o(cnt));

  task automatic results;
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_count++;
    $display("BAD %0t no answer", $time);
    results;
  endtask
  function automatic logic [9:0] code(input int a, input int g);
    int v;
    v = (a * g) >>> 14;
    if (v > 511) v = 511;
    if (v < -512) v = -512;
    return 10'(v + 512);
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    r = bresp;
    bready <= 1'b0;
    if (n == 40 && !bvalid) hang;
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40 && !rvalid) hang;
  endtask
  task automatic set(input int a, input int b, input int c, input int e);
    @(posedge clk);
    air <= 12'(a);
    aif <= 12'(b);
    aqr <= 12'(c);
    aqf <= 12'(e);
  endtask
  task automatic mode(input logic e, input logic s, input logic m, input logic f);
    @(posedge clk);
    ext <= e;
    desp <= s;
    dmxp <= m;
    fsp <= f;
    repeat (40) @(posedge clk);
  endtask
  task automatic lat(input logic s, input logic [9:0] want, input int n_exp);
    int n;
    logic [9:0] v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      v = s ? id : ip;
    end while (v !== want && n < 60);
    chk(n, n_exp);
    if (v !== want) hang;
  endtask

  initial begin
    {rstn, ext, desp, dmxp, fsp, stall} = 6'h03;
    {air, aif, aqr, aqf} = 48'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(oen, 1'b1);
    rd(32'h0000_000C);
    chk(d, 32'h0000_4000);
    rd(32'h0000_0008);
    chk(r, `DALR_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(32'h0000_0040, 32'h0000_0001);
    chk(r, `DALR_RESP_SLVERR);
    set(100, 77, -100, 55);
    lat(0, code(100, gain_hi), lat_p);
    chk(qp, code(-100, gain_hi));
    set(2047, 0, -2048, 0);
    lat(0, 10'h3FF, lat_p);
    chk(qp, 10'h000);
    mode(0, 0, 0, 0);
    set(100, 0, -100, 0);
    lat(0, code(100, gain_lo), lat_p);
    chk(qp, code(-100, gain_lo));
    mode(0, 0, 1, 1);
    set(200, 0, -200, 0);
    lat(0, code(200, gain_hi), lat_p);
    lat(1, code(200, gain_hi), 1);
    chk(qd, code(-200, gain_hi));
    chk(oen, 1'b0);
    mode(0, 1, 1, 1);
    set(60, -60, 300, 400);
    lat(0, code(60, gain_hi), lat_p);
    chk(qp, code(-60, gain_hi));
    lat(1, code(60, gain_hi), 1);
    chk(qd, code(-60, gain_hi));
    wr(32'h0000_0000, 32'h0000_0007);
    mode(1, 0, 0, 0);
    set(80, 90, 100, 120);
    lat(0, code(100, gain_hi), lat_p);
    chk(qp, code(120, gain_hi));
    wr(32'h0000_0000, 32'h0000_000B);
    set(140, 150, 140, 150);
    lat(0, code(140, gain_hi), lat_p);
    chk(qp, code(150, gain_hi));
    wr(32'h0000_0000, 32'h0000_000F);
    rd(32'h0000_0000);
    chk(d, 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0002);
    wr(32'h0000_000C, 32'h0000_2000);
    wr(32'h0000_002C, 32'h0000_FFFF);
    rd(32'h0000_002C);
    chk(d, 32'h0000_7FFF);
    set(100, 0, -100, 0);
    lat(0, code(100, 32'h0000_2000), lat_p);
    chk(qp, code(-100, 32'h0000_7FFF));
    rd(32'h0000_0004);
    chk(d, 32'h0000_0005);
    wr(32'h0000_0000, 32'h0000_0007);
    mode(0, 1, 0, 1);
    set(30, 40, 50, 60);
    lat(0, code(30, gain_hi), lat_p);
    chk(qp, code(40, gain_hi));
    chk(oen, 1'b1);
    set(222, 0, 0, 0);
    repeat (40) @(posedge clk);
    wr(32'h0000_0000, 32'h0000_0010);
    repeat (20) @(posedge clk);
    wr(32'h0000_0000, 32'h0000_0000);
    rd(32'h0000_0004);
    chk(d[31:16] != 16'h0000, 1'b1);
    chk(sv, 1'b1);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    chk(cnt, 8'h08);
    chk(last, code(222, gain_hi));
    chk(sv, 1'b0);
    results;
  end
endmodule
